// ---- rsl_regs.svh ----
// Constants of the radio serial slave: address map, reset values, state codes.
// Assumes inclusion by bare name from the package and the slave; defines only.
// How it works
// - Reset loads every config register default
// - Bytes shift most significant bit first
// - Select rising mid-byte cancels that transfer
// - Output low at once, else after crystal
// - Status byte returned for every header and write data byte
// - Status bit 7 high until crystal ready
// - Status bits 6:4 carry main state code
// - Idle code may stand for transitional states
// - Count: receive bytes on read, else free
// - Four-bit count saturates at fifteen
// - Burst address counter increments each byte, holds at 0x3F
// - Address 0x3F reaches transmit/receive FIFOs
// - 0x30-0x3D: burst status read, else strobe
`ifndef RSL_REGS_SVH
`define RSL_REGS_SVH
`define RSL_CFG_LAST     6'h2e
`define RSL_STAT_FIRST   6'h30
`define RSL_STAT_LAST    6'h3d
`define RSL_FIFO_ADDR    6'h3f
`define RSL_STB_FLUSH_RX 6'h3a
`define RSL_STB_FLUSH_TX 6'h3b
`define RSL_CFG_RST      8'h00
`define RSL_SYNC_RST     4'h8
`define RSL_ST_IDLE      3'h0
`define RSL_ST_RX        3'h1
`define RSL_ST_TX        3'h2
`define RSL_ST_FAST_TX   3'h3
`define RSL_ST_CAL       3'h4
`define RSL_ST_SETTLE    3'h5
`define RSL_ST_RX_OVF    3'h6
`define RSL_ST_TX_UNF    3'h7
`define RSL_FIFO_DEPTH   5'h10
`define RSL_CNT_MAX      4'hf
`endif

// ---- rsl_pkg.sv ----
// Types shared by the radio serial slave.
// Assumes rsl_regs.svh is reachable on the include path.
`include "rsl_regs.svh"
package rsl_pkg;
  typedef enum logic [2:0] {
    ST_OFF  = 3'b001,
    ST_HDR  = 3'b010,
    ST_DATA = 3'b100
  } rsl_xfer_t;

  typedef struct packed {
    logic       rw;
    logic       burst;
    logic [5:0] addr;
  } rsl_hdr_t;

  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] data;
  } rsl_cfg_wr_t;

  typedef struct packed {
    logic       rdy_n;
    logic [2:0] state;
    logic [3:0] count;
  } rsl_status_t;
endpackage

// ---- rsl_spi_slave.sv ----
// Four-wire serial slave with status byte, config registers and data FIFOs.
// Assumes pins arrive asynchronous to clk and the radio core runs on clk.
`timescale 1ns/10ps
`default_nettype none
`include "rsl_regs.svh"

module rsl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // Fill side
  input  wire logic                in_valid,
  output logic                     in_ready,
  input  wire logic [WIDTH-1:0]    in_data,
  // Drain side
  output logic                     out_valid,
  input  wire logic                out_ready,
  output logic [WIDTH-1:0]         out_data,
  // Control and level
  input  wire logic                flush,
  output logic [$clog2(DEPTH):0]   level
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = cnt_q != (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_q[rd_q];
  assign level     = cnt_q;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Flush wins over a push in the same cycle; the byte is discarded
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (flush) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_q + AW'(push);
      rd_q  <= rd_q + AW'(pop);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module rsl_spi_slave (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // Serial pins
  input  wire logic               select_low,
  input  wire logic               sclk,
  input  wire logic               si,
  output logic                    so_o,
  output logic                    so_oe_n,
  // Radio core status
  input  wire logic               crystal_oscillator_ok,
  input  wire logic [2:0]         main_state,
  // Transmit FIFO drain
  output logic                    tx_valid,
  input  wire logic               tx_ready,
  output logic [7:0]              tx_data,
  // Receive FIFO fill
  input  wire logic               rx_valid,
  output logic                    rx_ready,
  input  wire logic [7:0]         rx_data,
  // Config writes and command strobes
  output logic                    cfg_we,
  output rsl_pkg::rsl_cfg_wr_t    cfg_wr,
  output logic                    cmd_valid,
  output logic [5:0]              cmd_addr,
  output logic                    flush_rx_strobe,
  output logic                    flush_tx_strobe
);
  localparam int NCFG = 47;

  // Synchronisers: {select_low, sclk, si, crystal ok}
  logic [3:0]            sync1_q;
  logic [3:0]            sync2_q;
  logic                  sclk_prev_q;
  logic                  sel_act;
  logic                  si_s;
  logic                  xtal_s;
  logic                  rise;
  logic                  fall;
  // Byte engine
  rsl_pkg::rsl_xfer_t    st_q;
  logic [2:0]            bits_q;
  logic [2:0]            obit_q;
  logic [6:0]            shift_q;
  logic                  byte_done;
  logic [7:0]            in_byte;
  rsl_pkg::rsl_hdr_t     hdr;
  rsl_pkg::rsl_hdr_t     cur_q;
  logic                  rw_q;
  logic                  resp_stat_q;
  logic [7:0]            rd_q;
  logic                  hdr_done;
  logic                  data_done;
  logic                  is_strobe;
  logic                  burst_cont;
  logic                  preload;
  logic [5:0]            nxt_addr;
  logic [5:0]            ld_addr;
  logic                  flush_ok;
  // Storage and FIFOs
  logic [7:0]            cfg_q [NCFG];
  logic [4:0]            tx_lvl;
  logic [4:0]            rx_lvl;
  logic [4:0]            tx_free;
  logic                  tx_push;
  logic                  tx_in_ready;
  logic                  rx_pop;
  logic                  rx_out_valid;
  logic [7:0]            rx_out_data;
  rsl_pkg::rsl_status_t  stat;
  logic [7:0]            stat_b;
  logic [7:0]            rd_val;

  function automatic logic [3:0] sat4(input logic [4:0] v);
    sat4 = (v > 5'h0f) ? `RSL_CNT_MAX : v[3:0];
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q     <= `RSL_SYNC_RST;
      sync2_q     <= `RSL_SYNC_RST;
      sclk_prev_q <= 1'b0;
    end else begin
      sync1_q     <= {select_low, sclk, si, crystal_oscillator_ok};
      sync2_q     <= sync1_q;
      sclk_prev_q <= sync2_q[2];
    end
  end

  assign sel_act = ~sync2_q[3];
  assign si_s    = sync2_q[1];
  assign xtal_s  = sync2_q[0];
  // Clock edges count only while selected
  assign rise    = sel_act & sync2_q[2] & ~sclk_prev_q;
  assign fall    = sel_act & ~sync2_q[2] & sclk_prev_q;

  assign byte_done = rise && bits_q == 3'h7;
  assign in_byte   = {shift_q, si_s};
  assign hdr       = rsl_pkg::rsl_hdr_t'(in_byte);
  assign is_strobe = !hdr.burst && hdr.addr >= `RSL_STAT_FIRST && hdr.addr <= `RSL_STAT_LAST;
  assign hdr_done  = st_q == rsl_pkg::ST_HDR && byte_done;
  assign data_done = st_q == rsl_pkg::ST_DATA && byte_done;
  // Status registers are single-byte reads even with the burst bit set
  assign burst_cont = cur_q.burst && !(cur_q.addr >= `RSL_STAT_FIRST && cur_q.addr <= `RSL_STAT_LAST);
  assign nxt_addr   = (cur_q.addr == `RSL_FIFO_ADDR) ? cur_q.addr : cur_q.addr + 6'h01;
  assign preload    = (hdr_done && !is_strobe && hdr.rw) || (data_done && cur_q.rw && burst_cont);
  assign ld_addr    = hdr_done ? hdr.addr : nxt_addr;
  assign flush_ok   = main_state == `RSL_ST_IDLE || main_state == `RSL_ST_RX_OVF
                      || main_state == `RSL_ST_TX_UNF;

  // Bit counters restart whenever select is high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bits_q  <= 3'h0;
      obit_q  <= 3'h0;
      shift_q <= 7'h00;
    end else if (!sel_act) begin
      bits_q <= 3'h0;
      obit_q <= 3'h0;
    end else if (rise) begin
      bits_q  <= bits_q + 3'h1;
      shift_q <= in_byte[6:0];
      if (byte_done) begin
        obit_q <= 3'h0;
      end
    end else if (fall && bits_q != 3'h0) begin
      obit_q <= obit_q + 3'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= rsl_pkg::ST_OFF;
    end else begin
      unique case (st_q)
        rsl_pkg::ST_OFF: begin
          if (sel_act) begin
            st_q <= rsl_pkg::ST_HDR;
          end
        end
        rsl_pkg::ST_HDR: begin
          if (!sel_act) begin
            st_q <= rsl_pkg::ST_OFF;
          end else if (hdr_done && !is_strobe) begin
            st_q <= rsl_pkg::ST_DATA;
          end
        end
        rsl_pkg::ST_DATA: begin
          if (!sel_act) begin
            st_q <= rsl_pkg::ST_OFF;
          end else if (data_done && !burst_cont) begin
            st_q <= rsl_pkg::ST_HDR;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_q <= '0;
    end else if (hdr_done) begin
      cur_q <= hdr;
    end else if (data_done && burst_cont) begin
      cur_q.addr <= nxt_addr;
    end
  end

  // Read/write bit is known after the first rising edge, ahead of bits 3:0
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rw_q <= 1'b0;
    end else if (st_q == rsl_pkg::ST_HDR && rise && bits_q == 3'h0) begin
      rw_q <= si_s;
    end
  end

  // Reads return data; headers, strobes and writes return status
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resp_stat_q <= 1'b1;
    end else if (st_q == rsl_pkg::ST_OFF) begin
      resp_stat_q <= 1'b1;
    end else if (hdr_done) begin
      resp_stat_q <= is_strobe || !hdr.rw;
    end else if (data_done) begin
      resp_stat_q <= !(burst_cont && cur_q.rw);
    end
  end

  always_comb begin
    rd_val = 8'h00;
    if (ld_addr <= `RSL_CFG_LAST) begin
      rd_val = cfg_q[ld_addr];
    end else if (ld_addr >= `RSL_STAT_FIRST && ld_addr <= `RSL_STAT_LAST) begin
      rd_val = {5'h00, main_state};
    end else if (ld_addr == `RSL_FIFO_ADDR) begin
      rd_val = rx_out_valid ? rx_out_data : 8'h00;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= 8'h00;
    end else if (preload) begin
      rd_q <= rd_val;
    end
  end

  // Receive byte leaves the FIFO when it is staged for shifting out
  assign rx_pop  = preload && ld_addr == `RSL_FIFO_ADDR && rx_out_valid;
  // A write into a full transmit FIFO is dropped; free count already shows 0
  assign tx_push = data_done && !cur_q.rw && cur_q.addr == `RSL_FIFO_ADDR && tx_in_ready;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NCFG; i++) begin
        cfg_q[i] <= `RSL_CFG_RST;
      end
    end else if (data_done && !cur_q.rw && cur_q.addr <= `RSL_CFG_LAST) begin
      cfg_q[cur_q.addr] <= in_byte;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_we <= 1'b0;
      cfg_wr <= '0;
    end else begin
      cfg_we <= data_done && !cur_q.rw && cur_q.addr <= `RSL_CFG_LAST;
      if (data_done) begin
        cfg_wr <= '{addr: cur_q.addr, data: in_byte};
      end
    end
  end

  // Flush strobes only act in idle, overflow or underflow
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_valid       <= 1'b0;
      cmd_addr        <= 6'h00;
      flush_rx_strobe <= 1'b0;
      flush_tx_strobe <= 1'b0;
    end else begin
      cmd_valid       <= hdr_done && is_strobe;
      flush_rx_strobe <= hdr_done && is_strobe && hdr.addr == `RSL_STB_FLUSH_RX && flush_ok;
      flush_tx_strobe <= hdr_done && is_strobe && hdr.addr == `RSL_STB_FLUSH_TX && flush_ok;
      if (hdr_done && is_strobe) begin
        cmd_addr <= hdr.addr;
      end
    end
  end

  rsl_fifo #(.WIDTH(8), .DEPTH(16)) u_tx_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (tx_push),
    .in_ready  (tx_in_ready),
    .in_data   (in_byte),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_data),
    .flush     (flush_tx_strobe),
    .level     (tx_lvl)
  );

  rsl_fifo #(.WIDTH(8), .DEPTH(16)) u_rx_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (rx_valid),
    .in_ready  (rx_ready),
    .in_data   (rx_data),
    .out_valid (rx_out_valid),
    .out_ready (rx_pop),
    .out_data  (rx_out_data),
    .flush     (flush_rx_strobe),
    .level     (rx_lvl)
  );

  assign tx_free    = `RSL_FIFO_DEPTH - tx_lvl;
  assign stat.rdy_n = ~xtal_s;
  // Core may hold idle through settling and calibration
  assign stat.state = main_state;
  assign stat.count = rw_q ? sat4(rx_lvl) : sat4(tx_free);
  assign stat_b     = stat;

  // Bit 7 is the live crystal flag until the header starts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      so_o    <= 1'b0;
      so_oe_n <= 1'b1;
    end else begin
      so_oe_n <= ~sel_act;
      so_o    <= sel_act && (resp_stat_q ? stat_b[3'h7 - obit_q] : rd_q[3'h7 - obit_q]);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_rdy;
    sel_act && st_q == rsl_pkg::ST_HDR && bits_q == 3'h0 && obit_q == 3'h0 |=> so_o == !$past(xtal_s);
  endproperty
  a_rdy: assert property (p_rdy) else $error("status bit 7 does not follow crystal");

  property p_abort;
    !sel_act |=> st_q == rsl_pkg::ST_OFF && bits_q == 3'h0 ##1 !byte_done;
  endproperty
  a_abort: assert property (p_abort) else $error("transfer not cancelled by select high");

  property p_sat;
    sel_act && !rw_q && tx_lvl == 5'h00 |-> stat.count == `RSL_CNT_MAX;
  endproperty
  a_sat: assert property (p_sat) else $error("free count not saturated");

  property p_burst;
    data_done && burst_cont && cur_q.addr <= `RSL_CFG_LAST |=> cur_q.addr == $past(cur_q.addr) + 6'h01;
  endproperty
  a_burst: assert property (p_burst) else $error("burst address did not advance");

  property p_strobe;
    hdr_done && !in_byte[6] && in_byte[5:0] >= `RSL_STAT_FIRST && in_byte[5:0] <= `RSL_STAT_LAST
      |=> cmd_valid && cmd_addr == $past(in_byte[5:0]) && st_q == rsl_pkg::ST_HDR;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe not issued");

  property p_rx_read;
    hdr_done && hdr.rw && hdr.addr == `RSL_FIFO_ADDR && rx_out_valid |-> rx_pop ##1 rd_q == $past(rx_out_data);
  endproperty
  a_rx_read: assert property (p_rx_read) else $error("receive FIFO byte not staged");

  property p_oe;
    sel_act |=> !so_oe_n;
  endproperty
  a_oe: assert property (p_oe) else $error("serial output not driven while selected");

  property p_state;
    sel_act && resp_stat_q && obit_q == 3'h1 && $stable(main_state) |=> so_o == $past(main_state[2]);
  endproperty
  a_state: assert property (p_state) else $error("state code bit 6 wrong");

  property p_msb;
    hdr_done |-> hdr.rw == rw_q;
  endproperty
  a_msb: assert property (p_msb) else $error("header not taken msb first");
endmodule
`default_nettype wire

// ---- rsl_host_model.sv ----
// Host controller model: bus master on the four-wire serial port, mode 0.
// Assumes the 8 ns bench clock as time base; serial clock period is 80 ns.
`timescale 1ns/10ps
`default_nettype none
module rsl_host_model (
  // Time base
  input  wire logic clk,
  // Serial pins
  output logic      select_low,
  output logic      sclk,
  output logic      si,
  input  wire logic so_o,
  input  wire logic so_oe_n
);
  initial begin
    select_low = 1'b1;
    sclk       = 1'b0;
    si         = 1'b0;
  end
  task automatic half();
    repeat (5) @(negedge clk);
  endtask
  // Select stays low until close; no clock edge before the output reads low
  task automatic open_frame(input int limit, output logic ok);
    int n;
    n = 0;
    select_low = 1'b0;
    while (!(so_oe_n === 1'b0 && so_o === 1'b0) && n < limit) begin
      @(negedge clk);
      n++;
    end
    ok = (n < limit);
  endtask
  // Header built by caller; n below 8 cuts a byte short for abort tests
  task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      si = tx[i];
      half();
      rx[i] = so_o;
      sclk = 1'b1;
      half();
      sclk = 1'b0;
    end
    repeat (13) @(negedge clk);
  endtask
  // Released data line shows the inverse so stale values cannot pass
  task automatic close_frame();
    select_low = 1'b1;
    si = ~si;
    repeat (8) @(negedge clk);
  endtask
  task automatic stray_clocks();
    repeat (4) begin
      half();
      sclk = 1'b1;
      half();
      sclk = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ---- rsl_spi_slave_tb_top.sv ----
// Bench for the serial slave: host model on the pins, core side by hand.
// Assumes the design files and rsl_host_model.sv are compiled first.
`timescale 1ns/10ps
`default_nettype none
module rsl_spi_slave_tb_top;
  logic                 clk, rst_n, select_low, sclk, si, so_o, so_oe_n;
  logic                 crystal_oscillator_ok, tx_valid, tx_ready, rx_valid, rx_ready;
  logic                 cfg_we, cmd_valid, flush_rx_strobe, flush_tx_strobe;
  logic [2:0]           main_state;
  logic [7:0]           tx_data, rx_data, sh, rd;
  logic [5:0]           cmd_addr;
  rsl_pkg::rsl_cfg_wr_t cfg_wr;
  logic                 ok;
  int                   fails = 0;
  int                   n_tests = 0;
  int                   n_we = 0;
  int                   n_cmd = 0;
  int                   n_ftx = 0;
  int                   n_frx = 0;
  int                   b, c;

  rsl_spi_slave uut (.clk, .rst_n, .select_low, .sclk, .si, .so_o, .so_oe_n, .crystal_oscillator_ok,
    .main_state, .tx_valid, .tx_ready, .tx_data, .rx_valid, .rx_ready, .rx_data, .cfg_we, .cfg_wr,
    .cmd_valid, .cmd_addr, .flush_rx_strobe, .flush_tx_strobe);
  rsl_host_model host (.clk, .select_low, .sclk, .si, .so_o, .so_oe_n);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    n_we  <= n_we + (cfg_we === 1'b1);
    n_cmd <= n_cmd + (cmd_valid === 1'b1);
    n_ftx <= n_ftx + (flush_tx_strobe === 1'b1);
    n_frx <= n_frx + (flush_rx_strobe === 1'b1);
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic frame2(input logic [7:0] h, input logic [7:0] d);
    host.open_frame(64, ok);
    host.shift(h, 8, sh);
    host.shift(d, 8, rd);
    host.close_frame();
  endtask
  task automatic strobe(input logic [7:0] h);
    host.open_frame(64, ok);
    host.shift(h, 8, sh);
    host.close_frame();
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic t_reset();
    check({so_oe_n, so_o, tx_valid, rx_ready}, 16'h9);
    frame2(8'h80, 8'h00);
    check(rd, 8'h00);
    frame2(8'hae, 8'h00);
    check(rd, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_cfg();
    b = n_we;
    frame2(8'h05, 8'ha5);
    check(sh, 8'h0f);
    check(rd, 8'h0f);
    check(n_we - b, 1);
    check({2'b00, cfg_wr}, 16'h05a5);
    host.open_frame(64, ok);
    host.shift(8'h50, 8, sh);
    for (int i = 1; i <= 3; i++) host.shift(8'(i * 17), 8, rd);
    host.close_frame();
    check(n_we - b, 4);
    check({2'b00, cfg_wr}, 16'h1233);
    frame2(8'h91, 8'h00);
    check(rd, 8'h22);
    frame2(8'h85, 8'h00);
    check(rd, 8'ha5);
    $display("test config done");
  endtask
  task automatic t_state();
    for (int s = 0; s < 8; s++) begin
      main_state = 3'(s);
      frame2(8'hf0, 8'h00);
      check(sh, {1'b0, 3'(s), 4'h0});
      check(rd, {5'h00, 3'(s)});
    end
    main_state = 3'h0;
    $display("test state done");
  endtask
  task automatic t_xtal();
    crystal_oscillator_ok = 1'b0;
    host.open_frame(40, ok);
    check({ok, so_o}, 16'h1);
    crystal_oscillator_ok = 1'b1;
    host.open_frame(64, ok);
    check(ok, 1'b1);
    host.shift(8'h85, 8, sh);
    host.shift(8'h00, 8, rd);
    host.close_frame();
    check(sh[7], 1'b0);
    $display("test crystal done");
  endtask
  task automatic t_fifo();
    main_state = 3'h2;
    host.open_frame(64, ok);
    host.shift(8'h7f, 8, sh);
    check(sh, 8'h2f);
    for (int i = 0; i < 17; i++) begin
      host.shift(8'(i + 1), 8, rd);
      check(rd, {4'h2, (i < 2) ? 4'hf : 4'(16 - i)});
    end
    host.close_frame();
    c = 0;
    tx_ready = 1'b1;
    repeat (24) begin
      if (tx_valid === 1'b1) begin
        c++;
        check(tx_data, 8'(c));
      end
      @(negedge clk);
    end
    tx_ready = 1'b0;
    check(c, 16);
    frame2(8'h7f, 8'h11);
    b = n_ftx;
    c = n_cmd;
    strobe(8'h3b);
    check({n_ftx - b, cmd_addr, tx_valid}, {1'b0, 6'h3b, 1'b1});
    main_state = 3'h7;
    strobe(8'h3b);
    check({n_ftx - b, tx_valid}, 16'h2);
    check(n_cmd - c, 2);
    $display("test transmit fifo done");
  endtask
  task automatic t_rx();
    c = 0;
    for (int k = 0; k < 20; k++) begin
      rx_valid = 1'b1;
      rx_data = 8'(8'h40 + k);
      if (rx_ready === 1'b1) c++;
      @(negedge clk);
    end
    rx_valid = 1'b0;
    check({c, rx_ready}, 16'h20);
    main_state = 3'h6;
    host.open_frame(64, ok);
    host.shift(8'hff, 8, sh);
    check(sh, 8'h6f);
    host.shift(8'h00, 8, rd);
    check(rd, 8'h40);
    host.shift(8'h00, 8, rd);
    check(rd, 8'h41);
    host.close_frame();
    b = n_frx;
    strobe(8'hba);
    frame2(8'hf0, 8'h00);
    check({n_frx - b, sh}, 16'h160);
    main_state = 3'h0;
    $display("test receive fifo done");
  endtask
  task automatic t_abort();
    host.stray_clocks();
    b = n_we;
    host.open_frame(64, ok);
    host.shift(8'h06, 8, sh);
    host.shift(8'hff, 4, rd);
    host.close_frame();
    host.open_frame(64, ok);
    host.shift(8'h07, 3, sh);
    host.close_frame();
    check(n_we - b, 0);
    frame2(8'h86, 8'h00);
    check(rd, 8'h00);
    frame2(8'h06, 8'h5a);
    check({2'b00, cfg_wr}, 16'h065a);
    $display("test abort done");
  endtask

  initial begin
    rst_n = 1'b0;
    crystal_oscillator_ok = 1'b1;
    main_state = 3'h0;
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    t_cfg();
    t_state();
    t_xtal();
    t_fifo();
    t_rx();
    t_abort();
    report_and_stop();
  end
  initial begin
    #400000;
    fails++;
    report_and_stop();
  end
endmodule
`default_nettype wire
